/* File: uplink_map_scheduler.sv */
// Hub-side uplink map scheduler: lays out each uplink frame from loaded grants.
// Assumes a Wishbone classic master for software and a terminal-facing map port.
//
// How it works
// R1: Terminal contends only for bandwidth requests.
// R2: Frame: one window, ranging, scheduled bursts.
// R3: Long bursts many blocks; short one PDU.
// R4: Short PDU burst carries nothing else.
// R5: Terminal starts preamble at granted symbol.
// R6: Ranging allocation adds 10-80 us guard. Code adds egt_us as loaded; out-of-range values only set egt_bad.
// R7: Scheduled allocation covers transmitter ramp-up.
// R8: Window and ranging always PHY mode one.
// R9: Preamble 16 or 32; ranging 32.
// R10: Terminal shortens final codeword below four PDUs.
// R11: Window ends at next entry start.
// R12: Terminal adds own round-trip delay.
// R13: Frame is always one millisecond.
// R14: Hub may reorder layout every frame.
// R15: Half-duplex terminals never send while receiving.
// R16: Avoid half-duplex grants during control zone.
// R17: TDD: no downlink TDMA portion.
// R18: TDD switching gaps between subframes.
// R19: TDD optional extra guard before uplink.
// R20: Entry: 4-bit code, 10-bit identity, 15-bit start.
// R21: Code 0110 marks contention window.
// R22: Terminal pads unused grants with dummies.
// R23: Terminal counts symbols from frame start.
`timescale 1ns/1ns
module uplink_map_scheduler #(
    parameter int unsigned DEPTH          = 16,
    parameter int unsigned SYMBOLS_PER_US = 20,
    parameter int unsigned FRAME_PERIOD   = uplink_map_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    // Wishbone classic slave
    input  wire logic                       wb_cyc,
    input  wire logic                       wb_stb,
    input  wire logic                       wb_we,
    input  wire logic [7:0]                 wb_adr,
    input  wire logic [3:0]                 wb_sel,
    input  wire logic [31:0]                wb_dat_w,
    output logic [31:0]                     wb_dat_r,
    output logic                            wb_ack,
    // Uplink map toward the terminals
    output logic                            frame_start,
    output logic                            map_valid,
    output logic                            map_last,
    output uplink_map_pkg::map_entry_s      map_entry
);
    import uplink_map_pkg::*;

    localparam int unsigned IDX_W = $clog2(DEPTH + 1);

    typedef struct packed {
        // Registers
        logic             enable;
        logic             tdd;
        logic             hfdd;
        logic             preamble_long;
        logic [14:0]      dl_end;
        logic [7:0]       switch_gap;
        logic [7:0]       egt_us;
        logic [7:0]       ramp_symbols;
        logic [7:0]       tdd_guard;
        logic [IDX_W-1:0] count;
        logic             dropped;
        logic             egt_bad;
        logic [15:0]      frame_count;
        // Bus answer
        logic             ack;
        logic [31:0]      dat_r;
        // Emission
        emit_state_e      fsm;
        logic [IDX_W-1:0] idx;
        logic [IDX_W-1:0] total;
        logic [15:0]      cursor;
        logic             window_seen;
        // Outputs
        logic             frame_start;
        logic             map_valid;
        logic             map_last;
        map_entry_s       map_entry;
    } sched_s;

    sched_s     state;
    sched_s     next_state;
    grant_s     grants [DEPTH];
    logic       tick;
    logic       bus_req;
    logic       push;
    grant_s     cur_grant;
    size_cfg_s  cfg;
    logic [15:0] length;
    logic       is_window;
    logic       is_legal;
    logic [15:0] ul_start;
    logic [15:0] hd_free;
    logic [15:0] start;
    logic [15:0] stop;

    // R13 fixed frame
    frame_timer #(
        .PERIOD (FRAME_PERIOD)
    ) u_frame (
        .clk_sys (clk_sys),
        .reset   (reset),
        .tick    (tick)
    );

    assign cur_grant = grants[state.idx[$clog2(DEPTH)-1:0]];
    assign cfg.preamble_long = state.preamble_long;
    assign cfg.ramp_symbols  = state.ramp_symbols;
    assign cfg.egt_symbols   = 16'(state.egt_us * SYMBOLS_PER_US);

    burst_sizer u_sizer (
        .grant     (cur_grant),
        .cfg       (cfg),
        .length    (length),
        .is_window (is_window),
        .is_legal  (is_legal)
    );

    assign bus_req = wb_cyc && wb_stb && !state.ack;
    assign push    = bus_req && wb_we && (wb_sel == 4'hF) && (wb_adr == REG_GRANT)
                     && (state.count < IDX_W'(DEPTH));

    always_comb begin
        // R17 uplink subframe after downlink
        // R18 switching gap
        // R19 extra guard
        if (state.tdd) begin
            ul_start = 16'(state.dl_end) + 16'(state.switch_gap) + 16'(state.tdd_guard);
        end else begin
            ul_start = 16'h0000;
        end
        hd_free = 16'(state.dl_end) + 16'(state.switch_gap);
        start   = state.cursor;
        // R15 no overlap with reception
        // R16 keep clear of control zone
        if (state.hfdd && !state.tdd && cur_grant.half_duplex && start < hd_free) begin
            start = hd_free;
        end
        stop = start + length;
    end

    always_comb begin
        next_state = state;
        next_state.frame_start = tick;
        next_state.map_valid   = 1'b0;
        next_state.map_last    = 1'b0;
        next_state.ack         = bus_req;
        next_state.egt_bad     = (state.egt_us < EGT_MIN_US) || (state.egt_us > EGT_MAX_US);

        // Register access
        if (bus_req) begin
            next_state.dat_r = 32'h0000_0000;
            unique case (wb_adr)
                REG_CTRL:   next_state.dat_r = {28'h0000000, state.preamble_long,
                                                state.hfdd, state.tdd, state.enable};
                REG_TIMING: next_state.dat_r = {8'h00, state.switch_gap, 1'b0, state.dl_end};
                REG_GUARD:  next_state.dat_r = {8'h00, state.tdd_guard, state.ramp_symbols,
                                                state.egt_us};
                REG_GRANT:  next_state.dat_r = 32'(state.count);
                REG_STATUS: next_state.dat_r = {state.frame_count, 13'h0000, state.egt_bad,
                                                state.dropped, state.fsm != ST_IDLE};
                default:    next_state.dat_r = 32'h0000_0000;
            endcase
            if (wb_we && wb_sel == 4'hF) begin
                unique case (wb_adr)
                    REG_CTRL: begin
                        next_state.enable        = wb_dat_w[0];
                        next_state.tdd           = wb_dat_w[1];
                        next_state.hfdd          = wb_dat_w[2];
                        next_state.preamble_long = wb_dat_w[3];
                        if (wb_dat_w[4]) begin
                            next_state.count = '0;
                        end
                    end
                    REG_TIMING: begin
                        next_state.dl_end     = wb_dat_w[14:0];
                        next_state.switch_gap = wb_dat_w[23:16];
                    end
                    REG_GUARD: begin
                        next_state.egt_us       = wb_dat_w[7:0];
                        next_state.ramp_symbols = wb_dat_w[15:8];
                        next_state.tdd_guard    = wb_dat_w[23:16];
                    end
                    REG_GRANT: begin
                        if (state.count >= IDX_W'(DEPTH)) begin
                            next_state.dropped = 1'b1;
                        end else begin
                            next_state.count = state.count + IDX_W'(1);
                        end
                    end
                    REG_STATUS: begin
                        if (wb_dat_w[1]) begin
                            next_state.dropped = 1'b0;
                        end
                    end
                    default: ;
                endcase
            end
        end

        // Emission of one map per frame
        unique case (state.fsm)
            ST_IDLE: begin
                // Start a cycle after the frame pulse so terminals restart their count first
                if (state.frame_start && state.enable) begin
                    next_state.fsm         = ST_EMIT;
                    next_state.idx         = '0;
                    next_state.total       = state.count;
                    next_state.cursor      = ul_start;
                    next_state.window_seen = 1'b0;
                    next_state.frame_count = state.frame_count + 16'h0001;
                end
            end
            ST_EMIT: begin
                if (state.idx >= state.total) begin
                    next_state.fsm = ST_FINISH;
                end else begin
                    next_state.idx = state.idx + IDX_W'(1);
                    // R2 one window only
                    if (!is_legal || (is_window && state.window_seen)
                        || stop > 16'h8000) begin
                        next_state.dropped = 1'b1;
                    end else begin
                        // R14 layout follows load order
                        // R20 entry fields
                        next_state.map_valid = 1'b1;
                        next_state.map_entry.usage             = cur_grant.usage;
                        next_state.map_entry.terminal_identity = cur_grant.terminal_identity;
                        next_state.map_entry.start_symbol      = start[14:0];
                        // R11 next start closes window
                        next_state.cursor      = stop;
                        next_state.window_seen = state.window_seen | is_window;
                    end
                end
            end
            ST_FINISH: begin
                next_state.map_valid = 1'b1;
                next_state.map_last  = 1'b1;
                next_state.map_entry.usage             = CODE_END;
                next_state.map_entry.terminal_identity = END_TID;
                next_state.map_entry.start_symbol      = state.cursor[14:0];
                next_state.fsm = ST_IDLE;
            end
            default: next_state.fsm = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state               <= '0;
            state.fsm           <= ST_IDLE;
            state.dl_end        <= TIMING_RESET[14:0];
            state.switch_gap    <= TIMING_RESET[23:16];
            state.egt_us        <= GUARD_RESET[7:0];
            state.ramp_symbols  <= GUARD_RESET[15:8];
            state.tdd_guard     <= GUARD_RESET[23:16];
            state.enable        <= CTRL_RESET[0];
        end else begin
            state <= next_state;
        end
    end

    // Grant table has no reset; entries beyond count are never read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            grants[state.count[$clog2(DEPTH)-1:0]] <= grant_s'(wb_dat_w[26:0]);
        end
    end

    assign wb_ack      = state.ack;
    assign wb_dat_r    = state.dat_r;
    assign frame_start = state.frame_start;
    assign map_valid   = state.map_valid;
    assign map_last    = state.map_last;
    assign map_entry   = state.map_entry;

endmodule : uplink_map_scheduler

/* File: uplink_map_pkg.sv */
// Shared constants and carriers for the hub-side uplink map scheduler.
// Assumes a 20 MHz system clock and a 15-bit channel symbol numbering per frame.
package uplink_map_pkg;

    // Clock and frame timing
    localparam int unsigned CLK_HZ        = 20_000_000;
    localparam int unsigned FRAME_TIME_US = 1000;
    localparam int unsigned FRAME_CYCLES  = FRAME_TIME_US * (CLK_HZ / 1_000_000);

    // Extra guard time limits, in microseconds
    localparam logic [7:0] EGT_MIN_US = 8'h0A;
    localparam logic [7:0] EGT_MAX_US = 8'h50;

    // Preamble lengths in symbols
    localparam logic [5:0] PREAMBLE_SHORT = 6'h10;
    localparam logic [5:0] PREAMBLE_LONG  = 6'h20;

    // Map entry and grant field widths
    localparam int unsigned CODE_W  = 4;
    localparam int unsigned TID_W   = 10;
    localparam int unsigned SYM_W   = 15;
    localparam int unsigned PAY_W   = 12;

    // Usage codes
    localparam logic [3:0] CODE_LONG_M1   = 4'h0;
    localparam logic [3:0] CODE_SHORT_M3  = 4'h5;
    localparam logic [3:0] CODE_WINDOW    = 4'h6;
    localparam logic [3:0] CODE_RANGING   = 4'h7;
    localparam logic [3:0] CODE_END       = 4'hF;

    // Identity used in the closing map entry; value is arbitrary
    localparam logic [9:0] END_TID = 10'h3FF;

    // Register byte offsets
    localparam logic [7:0] REG_CTRL   = 8'h00;
    localparam logic [7:0] REG_TIMING = 8'h04;
    localparam logic [7:0] REG_GUARD  = 8'h08;
    localparam logic [7:0] REG_GRANT  = 8'h0C;
    localparam logic [7:0] REG_STATUS = 8'h10;

    // Reset values
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
    localparam logic [31:0] TIMING_RESET = 32'h0004_0000;
    localparam logic [31:0] GUARD_RESET  = 32'h0004_040A;

    // One uplink map entry, first-sent field on the left
    typedef struct packed {
        logic [CODE_W-1:0] usage;
        logic [TID_W-1:0]  terminal_identity;
        logic [SYM_W-1:0]  start_symbol;
    } map_entry_s;

    // One grant as loaded by software
    typedef struct packed {
        logic              half_duplex;
        logic [PAY_W-1:0]  payload_symbols;
        logic [TID_W-1:0]  terminal_identity;
        logic [CODE_W-1:0] usage;
    } grant_s;

    // Sizing configuration shared by the sizer
    typedef struct packed {
        logic        preamble_long;
        logic [7:0]  ramp_symbols;
        logic [15:0] egt_symbols;
    } size_cfg_s;

    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_EMIT   = 2'b01,
        ST_FINISH = 2'b11
    } emit_state_e;

endpackage : uplink_map_pkg

/* File: frame_timer.sv */
// Free-running frame tick generator.
// Assumes synchronous active-high reset; one pulse per frame period.
`timescale 1ns/1ns
module frame_timer #(
    parameter int unsigned PERIOD = uplink_map_pkg::FRAME_CYCLES
) (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic reset,
    // Tick out
    output logic      tick
);
    import uplink_map_pkg::*;

    typedef struct packed {
        logic [31:0] count;
        logic        tick;
    } timer_s;

    timer_s state;
    timer_s next_state;

    always_comb begin
        next_state = state;
        next_state.tick = 1'b0;
        if (state.count >= 32'(PERIOD - 1)) begin
            next_state.count = 32'h0000_0000;
            next_state.tick = 1'b1;
        end else begin
            next_state.count = state.count + 32'h0000_0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
    end

    assign tick = state.tick;

endmodule : frame_timer

/* File: burst_sizer.sv */
// Works out how many symbols one grant occupies and how it is classed.
// Purely combinational; the caller registers the result.
`timescale 1ns/1ns
module burst_sizer (
    // Grant and configuration
    input  uplink_map_pkg::grant_s    grant,
    input  uplink_map_pkg::size_cfg_s cfg,
    // Result
    output logic [15:0]               length,
    output logic                      is_window,
    output logic                      is_legal
);
    import uplink_map_pkg::*;

    logic        ranging;
    logic [5:0]  preamble;

    always_comb begin
        ranging   = (grant.usage == CODE_RANGING);
        // R21 window code
        is_window = (grant.usage == CODE_WINDOW);
        is_legal  = (grant.usage <= CODE_RANGING);
        // R9 preamble length
        preamble  = (ranging || cfg.preamble_long) ? PREAMBLE_LONG : PREAMBLE_SHORT;
        // R7 ramp-up included
        length    = 16'(preamble) + 16'(grant.payload_symbols) + 16'(cfg.ramp_symbols);
        // R6 guard on ranging
        if (ranging) begin
            length = length + cfg.egt_symbols;
        end
    end

endmodule : burst_sizer

/* File: uplink_map_scheduler_assertions.sv */
// Port-level checker for the uplink map scheduler.
// Assumes one clock domain with the synchronous reset; bound below.
`timescale 1ns/1ns
module uplink_map_checker #(
    parameter int unsigned FRAME_PERIOD = 200
) (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  reset,
    // Register bus
    input wire logic                  wb_cyc,
    input wire logic                  wb_stb,
    input wire logic                  wb_we,
    input wire logic [7:0]            wb_adr,
    input wire logic [3:0]            wb_sel,
    input wire logic [31:0]           wb_dat_w,
    input wire logic [31:0]           wb_dat_r,
    input wire logic                  wb_ack,
    // Map link
    input wire logic                  frame_start,
    input wire logic                  map_valid,
    input wire logic                  map_last,
    input uplink_map_pkg::map_entry_s map_entry
);
    import uplink_map_pkg::*;
    int          fcnt;
    logic        seen;
    logic        win_seen;
    logic        have_prev;
    logic [14:0] prev_start;
    // Per-frame bookkeeping restarts at each frame tick
    always_ff @(posedge clk_sys) begin
        if (reset || frame_start) begin
            fcnt      <= 0;
            win_seen  <= 1'b0;
            have_prev <= 1'b0;
        end else begin
            fcnt <= fcnt + 1;
            if (map_valid) begin
                have_prev  <= 1'b1;
                prev_start <= map_entry.start_symbol;
            end
            if (map_valid && map_entry.usage == CODE_WINDOW) begin
                win_seen <= 1'b1;
            end
        end
    end
    // The first tick after reset has no period to measure
    always_ff @(posedge clk_sys) seen <= !reset && (seen || frame_start);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    sequence s_wb_req; wb_cyc && wb_stb && !wb_ack; endsequence
    sequence s_close;
        map_entry.usage == CODE_END && map_entry.terminal_identity == END_TID;
    endsequence
    property p_ack_resp; s_wb_req |=> wb_ack; endproperty
    property p_ack_one; wb_ack |=> !wb_ack; endproperty
    property p_unmapped; wb_ack && !wb_we && wb_adr > REG_STATUS |-> wb_dat_r == 32'h0; endproperty
    property p_frame; frame_start && seen |-> fcnt == FRAME_PERIOD - 1; endproperty
    property p_no_early; frame_start |=> !map_valid; endproperty
    property p_close; map_last |-> map_valid ##0 s_close; endproperty
    property p_legal; map_valid && !map_last |-> map_entry.usage <= CODE_RANGING; endproperty
    property p_one_win; map_valid && map_entry.usage == CODE_WINDOW |-> !win_seen; endproperty
    property p_order; map_valid && have_prev |-> map_entry.start_symbol >= prev_start; endproperty
    a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
    a_ack_one: assert property (p_ack_one) else $error("ack held too long");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    a_frame: assert property (p_frame) else $error("frame period wrong");
    a_no_early: assert property (p_no_early) else $error("entry right after tick");
    a_close: assert property (p_close) else $error("bad closing entry");
    a_legal: assert property (p_legal) else $error("unknown usage code sent");
    a_one_win: assert property (p_one_win) else $error("second window");
    a_order: assert property (p_order) else $error("start symbols out of order");
endmodule : uplink_map_checker
bind uplink_map_scheduler uplink_map_checker #(.FRAME_PERIOD(FRAME_PERIOD)) u_chk (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .frame_start(frame_start), .map_valid(map_valid),
    .map_last(map_last), .map_entry(map_entry));

/* File: terminal_model.sv */
// Behavioural access terminal listening to the uplink map.
// Assumes map pulses on the hub clock; records one frame at a time.
`timescale 1ns/1ns
module terminal_model #(
    parameter logic [9:0] MY_TID = 10'h001,
    parameter int         ROUND_TRIP_DELAY    = 3
) (
    // Clock and reset
    input wire logic                  clk_sys,
    input wire logic                  reset,
    // Preamble length agreed at start-up
    input wire logic                  preamble_long,
    // Map from the hub
    input wire logic                  frame_start,
    input wire logic                  map_valid,
    input wire logic                  map_last,
    input uplink_map_pkg::map_entry_s map_entry
);
    import uplink_map_pkg::*;
    int          n;
    int          sym;
    int          tx_sym;
    int          pre_len;
    int          win_len;
    int          mode;
    logic        tx_go;
    logic [14:0] st [0:15];
    logic [3:0]  us [0:15];
    always @(posedge clk_sys) begin
        if (reset || frame_start) begin
            n      <= 0;
            sym    <= 0;
            tx_sym <= -1;
        end else begin
            sym <= sym + 1;
            if (map_valid && !map_last && n < 15 || map_last) begin
                st[n] <= map_entry.start_symbol;
                us[n] <= map_entry.usage;
                n     <= n + 1;
            end
            if (map_valid && n > 0 && us[n-1] == CODE_WINDOW) begin
                win_len <= map_entry.start_symbol - st[n-1];
            end
            if (map_valid && map_entry.terminal_identity == MY_TID) begin
                tx_sym <= map_entry.start_symbol + ROUND_TRIP_DELAY;
                // mode one and long preamble for ranging
                pre_len <= (map_entry.usage == CODE_RANGING || preamble_long) ? 32 : 16;
                mode    <= (map_entry.usage == CODE_RANGING) ? 1 : map_entry.usage % 3 + 1;
            end
        end
    end
    // one burst kind, PDU layer pads it
    assign tx_go = (sym == tx_sym);
endmodule : terminal_model

/* File: uplink_map_scheduler_tb_top.sv */
// Self-checking bench for the uplink map scheduler.
// Assumes the terminal model and the bound checker are compiled first.
`timescale 1ns/1ns
module uplink_map_scheduler_tb_top;
    import uplink_map_pkg::*;
    localparam int unsigned FP = 200;
    logic        clk_sys = 1'b0;
    logic        reset = 1'b1;
    logic        wb_cyc = 1'b0;
    logic        wb_stb = 1'b0;
    logic        wb_we = 1'b0;
    logic        plong = 1'b0;
    logic [7:0]  wb_adr = 8'h00;
    logic [7:0]  v;
    logic [3:0]  wb_sel = 4'hF;
    logic [31:0] wb_dat_w = 32'h0;
    logic [31:0] wb_dat_r;
    logic [31:0] rd;
    logic        wb_ack, frame_start, map_valid, map_last;
    map_entry_s  map_entry;
    int          err_count = 0;
    int          checked = 0;
    int          cycles = 0;
    always #25 clk_sys = ~clk_sys;
    uplink_map_scheduler #(.DEPTH(16), .SYMBOLS_PER_US(20), .FRAME_PERIOD(FP)) uut (
        .clk_sys(clk_sys), .reset(reset), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
        .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
        .wb_ack(wb_ack), .frame_start(frame_start), .map_valid(map_valid),
        .map_last(map_last), .map_entry(map_entry));
    terminal_model #(.MY_TID(10'h001), .ROUND_TRIP_DELAY(3)) u_term (
        .clk_sys(clk_sys), .reset(reset), .preamble_long(plong), .frame_start(frame_start),
        .map_valid(map_valid), .map_last(map_last), .map_entry(map_entry));
    task close_out;
        $display("mismatches %0d, comparisons %0d", err_count, checked);
        if (err_count == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t: got %h, wanted %h", $time, seen, exp);
        end
    endtask : chk
    // Classic single cycle; request held until ack is sampled
    task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        wb_cyc   <= 1'b1;
        wb_stb   <= 1'b1;
        wb_we    <= we;
        wb_adr   <= a;
        wb_dat_w <= d;
        do begin
            @(posedge clk_sys);
            n++;
        end while (wb_ack !== 1'b1 && n < 20);
        rd = wb_dat_r;
        chk(32'(wb_ack), 32'h1);
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        wb_we  <= 1'b0;
    endtask : wb
    function automatic logic [31:0] gw(logic hd, logic [11:0] p, logic [9:0] t, logic [3:0] u);
        return {5'h00, hd, p, t, u};
    endfunction : gw
    // Whole map of the next frame lands in the terminal model
    task wait_map;
        do @(posedge clk_sys); while (frame_start !== 1'b1);
        do @(posedge clk_sys); while (map_last !== 1'b1);
        @(posedge clk_sys);
    endtask : wait_map
    task chk_map(input int cnt, input logic [59:0] s);
        chk(32'(u_term.n), 32'(cnt));
        for (int i = 0; i < cnt; i++) chk(32'(u_term.st[i]), 32'(s[15*i +: 15]));
    endtask : chk_map
    task t_reset;
        int n;
        wb(1'b0, REG_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        wb(1'b0, REG_TIMING, 32'h0);
        chk(rd, TIMING_RESET);
        wb(1'b0, REG_GUARD, 32'h0);
        chk(rd, GUARD_RESET);
        wb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        n = 0;
        do @(posedge clk_sys); while (frame_start !== 1'b1);
        do begin
            @(posedge clk_sys);
            n++;
        end while (frame_start !== 1'b1 && n < 1000);
        chk(32'(n), 32'(FP));
    endtask : t_reset
    task t_fdd;
        wb(1'b1, REG_CTRL, 32'h1);
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h064, 10'h001, CODE_LONG_M1));
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h014, 10'h000, CODE_WINDOW));
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h00A, 10'h002, CODE_RANGING));
        wb(1'b0, REG_GRANT, 32'h0);
        chk(rd, 32'h3);
        // Partial-lane write must leave the register alone
        wb_sel <= 4'h3;
        wb(1'b1, REG_CTRL, 32'h0);
        wb_sel <= 4'hF;
        wb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h1);
        wait_map;
        chk_map(4, {15'h0196, 15'h00A0, 15'h0078, 15'h0000});
        chk(32'(u_term.us[1]), 32'(CODE_WINDOW));
        chk(32'(u_term.us[3]), 32'(CODE_END));
        chk(32'(u_term.win_len), 32'h28);
        chk(32'(u_term.tx_sym), 32'h3);
        chk(32'(u_term.pre_len), 32'h10);
        chk(32'(u_term.mode), 32'h1);
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h005, 10'h003, 4'h8));
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h005, 10'h004, CODE_WINDOW));
        wait_map;
        chk(32'(u_term.n), 32'h4);
        wb(1'b0, REG_STATUS, 32'h0);
        chk(32'(rd[1]), 32'h1);
    endtask : t_fdd
    task t_tdd;
        plong <= 1'b1;
        wb(1'b1, REG_CTRL, 32'h0000_001B);
        wb(1'b1, REG_TIMING, 32'h0004_0032);
        wb(1'b1, REG_GUARD, 32'h0006_040A);
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h008, 10'h001, CODE_LONG_M1));
        wait_map;
        chk_map(2, {30'h0, 15'h0068, 15'h003C});
        chk(32'(u_term.pre_len), 32'h20);
        chk(32'(u_term.tx_sym), 32'h3F);
    endtask : t_tdd
    task t_hfdd;
        plong <= 1'b0;
        wb(1'b1, REG_CTRL, 32'h0000_0015);
        wb(1'b1, REG_GRANT, gw(1'b1, 12'h008, 10'h001, CODE_LONG_M1));
        wb(1'b1, REG_GRANT, gw(1'b0, 12'h008, 10'h002, CODE_SHORT_M3));
        wait_map;
        chk_map(3, {15'h0, 15'h006E, 15'h0052, 15'h0036});
    endtask : t_hfdd
    task t_egt;
        for (int i = 0; i < 4; i++) begin
            v = (i < 2) ? EGT_MIN_US - 8'h01 + 8'(i) : EGT_MAX_US + 8'(i - 2);
            wb(1'b1, REG_GUARD, {16'h0000, 8'h04, v});
            wb(1'b0, REG_STATUS, 32'h0);
            chk(32'(rd[2]), 32'(v < EGT_MIN_US || v > EGT_MAX_US));
        end
    endtask : t_egt
    initial begin
        repeat (12) @(posedge clk_sys);
        reset <= 1'b0;
        t_reset;
        t_fdd;
        t_tdd;
        t_hfdd;
        t_egt;
        close_out;
    end
    // A hang ends the run as a mismatch
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            close_out;
        end
    end
endmodule : uplink_map_scheduler_tb_top
